// file: control_timer_ctrl_regs.sv
module control_timer_ctrl_regs #(
  parameter int NUM_CH   = 4,
  parameter int SYNC_LEN = ctrl_timer_pkg::SYNC_CYCLES
) (
  // clock, reset, enable
  input  wire logic                              CLOCK_I,
  input  wire logic                              RST_I,
  input  wire logic                              CE_I,
  // axi4-lite write
  input  wire logic [ctrl_timer_pkg::ADDR_W-1:0] AWADDR_I,
  input  wire logic                              AWVALID_I,
  output logic                                   AWREADY_O,
  input  wire logic [31:0]                       WDATA_I,
  input  wire logic [3:0]                        WSTRB_I,
  input  wire logic                              WVALID_I,
  output logic                                   WREADY_O,
  output logic [1:0]                             BRESP_O,
  output logic                                   BVALID_O,
  input  wire logic                              BREADY_I,
  // axi4-lite read
  input  wire logic [ctrl_timer_pkg::ADDR_W-1:0] ARADDR_I,
  input  wire logic                              ARVALID_I,
  output logic                                   ARREADY_O,
  output logic [31:0]                            RDATA_O,
  output logic [1:0]                             RRESP_O,
  output logic                                   RVALID_O,
  input  wire logic                              RREADY_I,
  // system and counter events
  input  wire logic                              WP_EN_I,
  input  wire logic                              STANDBY_I,
  input  wire logic                              OVF_EVT_I,
  input  wire logic                              RETRIG_EVT_I,
  input  wire logic                              UPD_COND_I,
  // timer controls
  output logic                                   TIMER_RUN_O,
  output logic                                   PRESC_TICK_O,
  output logic                                   COUNT_RELOAD_O,
  output logic                                   CMD_STOP_O,
  output logic                                   CMD_COUNT_READ_SYNC_COMMAND_O,
  output logic                                   BUF_COPY_O,
  output logic                                   LOCK_UPDATE_O,
  output logic                                   SOFT_RESET_O,
  output logic [3:0]                             CAPTURE_EN_O,
  output logic [2:0]                             DITHER_BITS_O
);
  import ctrl_timer_pkg::*;

  initial
  begin
    if (NUM_CH < 1 || NUM_CH > 4)
      $error("NUM_CH must be 1 to 4");
    if (SYNC_LEN < 1 || SYNC_LEN > 15)
      $error("SYNC_LEN must be 1 to 15");
  end

  localparam logic [3:0] CH_MASK = 4'((1 << NUM_CH) - 1);
  localparam logic [3:0] SYNC_LD = 4'(SYNC_LEN);
  localparam logic [ADDR_W-1:0] A_PRI = ADDR_W'({IDX_PRIMARY, 2'b00});
  localparam logic [ADDR_W-1:0] A_CLR = ADDR_W'({IDX_CLEAR, 2'b00});
  localparam logic [ADDR_W-1:0] A_SET = ADDR_W'({IDX_SET, 2'b00});
  localparam logic [ADDR_W-1:0] A_BSY = ADDR_W'({IDX_BUSY, 2'b00});

  // primary control fields
  logic [3:0]  cpten_r;
  logic        auto_lock_update_r;
  psync_t      psync_r;
  logic        run_in_standby_r;
  logic [2:0]  presc_r;
  logic [1:0]  res_r;
  logic        enable_bit_r;
  logic        software_reset_request_r;
  logic        enabled_r;
  // secondary control shared by set and clear views
  logic        lock_buffer_update_r;
  cmd_t        pend_r;
  logic [7:0]  stage_r;
  logic        stage_set_r;
  // bus side
  logic              aw_got_r;
  logic              w_got_r;
  logic [ADDR_W-1:0] waddr_r;
  logic [31:0]       wdata_r;
  logic [3:0]        wstrb_r;
  // timer side
  logic [9:0]  pcnt_r;
  logic        reload_wait_r;

  logic        wr_fire;
  logic        wr_ok;
  logic        wr_pri;
  logic        wr_ctrlb;
  logic        software_reset_request_go;
  logic        en_go;
  logic        prot_en;
  logic [2:0]  sgo;
  logic [2:0]  sbusy;
  logic [2:0]  sdone;
  logic [9:0]  pterm;
  logic        running;
  logic        tick;
  logic        exec;
  logic        retrig;
  logic        apply_set;
  logic        apply_clr;
  cmd_t        stage_cmd;
  logic [31:0] pri_view;
  logic [31:0] rd_data;
  logic        rd_hit;

  // the whole handshake waits for the response slot, so one write at a time
  assign AWREADY_O = !aw_got_r && !BVALID_O;
  assign WREADY_O  = !w_got_r && !BVALID_O;
  assign ARREADY_O = !RVALID_O;
  assign wr_fire   = aw_got_r && w_got_r && !BVALID_O;

  always_ff @(posedge CLOCK_I)
  begin
    if (RST_I)
    begin
      aw_got_r <= 1'b0;
      w_got_r  <= 1'b0;
      waddr_r  <= '0;
      wdata_r  <= 32'h0;
      wstrb_r  <= 4'h0;
    end
    else if (CE_I)
    begin
      if (AWVALID_I && AWREADY_O)
      begin
        aw_got_r <= 1'b1;
        waddr_r  <= AWADDR_I;
      end
      else if (wr_fire)
        aw_got_r <= 1'b0;
      if (WVALID_I && WREADY_O)
      begin
        w_got_r <= 1'b1;
        wdata_r <= WDATA_I;
        wstrb_r <= WSTRB_I;
      end
      else if (wr_fire)
        w_got_r <= 1'b0;
    end
  end

  always_ff @(posedge CLOCK_I)
  begin
    if (RST_I)
    begin
      BVALID_O <= 1'b0;
      BRESP_O  <= RESP_OKAY;
    end
    else if (CE_I)
    begin
      if (wr_fire)
      begin
        BVALID_O <= 1'b1;
        BRESP_O  <= (wr_pri || wr_ctrlb || waddr_r == A_BSY) ?
                    RESP_OKAY : RESP_SLVERR;
      end
      else if (BREADY_I)
        BVALID_O <= 1'b0;
    end
  end

  // write decode; protection and an ongoing reset drop the write silently
  assign prot_en  = enable_bit_r || enabled_r;
  assign wr_ok    = wr_fire && !WP_EN_I && !software_reset_request_r;
  assign wr_pri   = waddr_r == A_PRI;
  assign wr_ctrlb = (waddr_r == A_CLR) || (waddr_r == A_SET);
  assign software_reset_request_go = wr_ok && wr_pri && wstrb_r[0]
                    && wdata_r[SOFTWARE_RESET_REQUEST_BIT];
  assign en_go    = wr_ok && wr_pri && wstrb_r[0] && !software_reset_request_go;
  assign sgo      = {wr_ok && wr_ctrlb && wstrb_r[0], en_go, software_reset_request_go};

  // one delay line per busy flag stands in for the timer clock crossing
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_sync
      logic [3:0] scnt_r;
      assign sbusy[gi] = scnt_r != 4'h0;
      assign sdone[gi] = scnt_r == 4'h1;
      always_ff @(posedge CLOCK_I)
      begin
        if (RST_I)
          scnt_r <= 4'h0;
        else if (CE_I)
        begin
          if (gi != 0 && sdone[0])
            scnt_r <= 4'h0;
          else if (sgo[gi])
            scnt_r <= SYNC_LD;
          else if (sbusy[gi])
            scnt_r <= scnt_r - 4'h1;
        end
      end
    end
  endgenerate

  // primary control: fields act at once, enable goes through the sync line
  always_ff @(posedge CLOCK_I)
  begin
    if (RST_I || (CE_I && sdone[0]))
    begin
      cpten_r      <= PRIMARY_RST[CPTEN_LSB +: 4];
      auto_lock_update_r      <= PRIMARY_RST[AUTO_LOCK_UPDATE_BIT];
      psync_r      <= psync_t'(PRIMARY_RST[PSYNC_LSB +: 2]);
      run_in_standby_r   <= PRIMARY_RST[RUN_IN_STANDBY_BIT];
      presc_r      <= PRIMARY_RST[PRESC_LSB +: 3];
      res_r        <= PRIMARY_RST[RES_LSB +: 2];
      enable_bit_r <= PRIMARY_RST[ENABLE_BIT];
      software_reset_request_r      <= PRIMARY_RST[SOFTWARE_RESET_REQUEST_BIT];
      enabled_r    <= 1'b0;
    end
    else if (CE_I)
    begin
      if (software_reset_request_go)
        software_reset_request_r <= 1'b1;
      if (en_go)
        enable_bit_r <= wdata_r[ENABLE_BIT];
      if (sdone[1])
        enabled_r <= enable_bit_r;
      if (wr_ok && wr_pri && !software_reset_request_go && !prot_en)
      begin
        if (wstrb_r[3])
          cpten_r <= wdata_r[CPTEN_LSB +: 4] & CH_MASK;
        if (wstrb_r[1])
        begin
          auto_lock_update_r    <= wdata_r[AUTO_LOCK_UPDATE_BIT];
          run_in_standby_r <= wdata_r[RUN_IN_STANDBY_BIT];
          presc_r    <= wdata_r[PRESC_LSB +: 3];
          if (wdata_r[PSYNC_LSB +: 2] != PSYNC_RSVD)
            psync_r <= psync_t'(wdata_r[PSYNC_LSB +: 2]);
        end
        if (wstrb_r[0])
          res_r <= wdata_r[RES_LSB +: 2];
      end
    end
  end

  // secondary control staging; applied when the transfer completes
  always_ff @(posedge CLOCK_I)
  begin
    if (RST_I)
    begin
      stage_r     <= CTRLB_RST;
      stage_set_r <= 1'b0;
    end
    else if (CE_I && sgo[2])
    begin
      stage_r     <= wdata_r[7:0];
      stage_set_r <= waddr_r == A_SET;
    end
  end

  assign stage_cmd = cmd_t'(stage_r[CMD_LSB +: 3]);
  assign apply_set = sdone[2] && stage_set_r;
  assign apply_clr = sdone[2] && !stage_set_r;

  // timer-side prescaler: divide by 2^shift, codes 5..7 skip shifts 5,7,9
  always_comb
  begin
    case (presc_r)
      3'h0: pterm = 10'h000;
      3'h1: pterm = 10'h001;
      3'h2: pterm = 10'h003;
      3'h3: pterm = 10'h007;
      3'h4: pterm = 10'h00f;
      3'h5: pterm = 10'h03f;
      3'h6: pterm = 10'h0ff;
      default: pterm = 10'h3ff;
    endcase
  end

  assign running = enabled_r && !(STANDBY_I && !run_in_standby_r);
  assign tick    = running && pcnt_r >= pterm;
  assign exec    = tick && pend_r != CMD_NONE;
  assign retrig  = running && (RETRIG_EVT_I ||
                   (exec && pend_r == CMD_RETRIG));

  always_ff @(posedge CLOCK_I)
  begin
    // a disabled divider restarts from zero, so a new divide value never
    // finds the count already past its terminal value
    if (RST_I || (CE_I && (sdone[0] || !enabled_r)))
      pcnt_r <= 10'h000;
    else if (CE_I)
    begin
      if (retrig && psync_r == PSYNC_RESYNC)
        pcnt_r <= 10'h000;
      else if (tick)
        pcnt_r <= 10'h000;
      else if (running)
        pcnt_r <= pcnt_r + 10'h001;
    end
  end

  // pending command and lock bit; hardware set wins over any clear but the soft reset
  always_ff @(posedge CLOCK_I)
  begin
    if (RST_I || (CE_I && sdone[0]))
    begin
      pend_r <= cmd_t'(CTRLB_RST[CMD_LSB +: 3]);
      lock_buffer_update_r <= CTRLB_RST[LOCK_BUFFER_UPDATE_BIT];
    end
    else if (CE_I)
    begin
      if (apply_set && stage_cmd != CMD_NONE
          && stage_r[CMD_LSB +: 3] <= 3'h4)
        pend_r <= stage_cmd;
      else if (exec)
        pend_r <= CMD_NONE;
      else if (apply_clr && stage_cmd != CMD_NONE
               && stage_cmd == pend_r)
        pend_r <= CMD_NONE;
      if ((auto_lock_update_r && running && (OVF_EVT_I || retrig))
          || (apply_set && stage_r[LOCK_BUFFER_UPDATE_BIT]))
        lock_buffer_update_r <= 1'b1;
      else if (apply_clr && stage_r[LOCK_BUFFER_UPDATE_BIT])
        lock_buffer_update_r <= 1'b0;
    end
  end

  // registered timer controls
  always_ff @(posedge CLOCK_I)
  begin
    if (RST_I)
    begin
      PRESC_TICK_O   <= 1'b0;
      COUNT_RELOAD_O <= 1'b0;
      CMD_STOP_O     <= 1'b0;
      CMD_COUNT_READ_SYNC_COMMAND_O <= 1'b0;
      BUF_COPY_O     <= 1'b0;
      SOFT_RESET_O   <= 1'b0;
      reload_wait_r  <= 1'b0;
    end
    else if (CE_I)
    begin
      PRESC_TICK_O   <= tick;
      CMD_STOP_O     <= exec && pend_r == CMD_STOP;
      CMD_COUNT_READ_SYNC_COMMAND_O <= exec && pend_r == CMD_COUNT_READ_SYNC_COMMAND;
      SOFT_RESET_O   <= sdone[0];
      // capture mode disables the lock on buffer copies
      BUF_COPY_O <= (UPD_COND_I || (exec && pend_r == CMD_UPDATE))
                    && (!lock_buffer_update_r || (cpten_r != 4'h0));
      COUNT_RELOAD_O <= 1'b0;
      if (retrig)
      begin
        case (psync_r)
          PSYNC_GCLK, PSYNC_RESYNC: COUNT_RELOAD_O <= 1'b1;
          PSYNC_PRESC: reload_wait_r <= 1'b1;
          default: reload_wait_r <= reload_wait_r;
        endcase
      end
      else if (reload_wait_r && tick)
      begin
        COUNT_RELOAD_O <= 1'b1;
        reload_wait_r  <= 1'b0;
      end
      if (sdone[0])
        reload_wait_r <= 1'b0;
    end
  end

  always_ff @(posedge CLOCK_I)
  begin
    if (RST_I)
    begin
      CAPTURE_EN_O  <= 4'h0;
      DITHER_BITS_O <= 3'h0;
      LOCK_UPDATE_O <= 1'b0;
      TIMER_RUN_O   <= 1'b0;
    end
    else if (CE_I)
    begin
      CAPTURE_EN_O  <= cpten_r;
      DITHER_BITS_O <= (res_r == 2'h0) ? 3'h0 :
                       3'(4'h3 + {2'h0, res_r});
      LOCK_UPDATE_O <= lock_buffer_update_r;
      TIMER_RUN_O   <= running;
    end
  end

  // read side
  assign pri_view = {4'h0, cpten_r, 9'h000, auto_lock_update_r, psync_r,
                     run_in_standby_r, presc_r, 1'b0, res_r, 3'h0,
                     enable_bit_r, software_reset_request_r};

  always_comb
  begin
    rd_hit  = 1'b1;
    if (ARADDR_I == A_PRI)
      rd_data = pri_view;
    else if (ARADDR_I == A_CLR || ARADDR_I == A_SET)
      rd_data = {24'h0, pend_r, 3'h0, lock_buffer_update_r, 1'b0};
    else if (ARADDR_I == A_BSY)
      rd_data = {29'h0, sbusy};
    else
    begin
      rd_data = 32'h0;
      rd_hit  = 1'b0;
    end
  end

  always_ff @(posedge CLOCK_I)
  begin
    if (RST_I)
    begin
      RVALID_O <= 1'b0;
      RDATA_O  <= 32'h0;
      RRESP_O  <= RESP_OKAY;
    end
    else if (CE_I)
    begin
      if (ARVALID_I && ARREADY_O)
      begin
        RVALID_O <= 1'b1;
        RDATA_O  <= rd_data;
        RRESP_O  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (RREADY_I)
        RVALID_O <= 1'b0;
    end
  end

  // checks
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (RST_I || !CE_I);

  property p_prot_hold;
    wr_fire && wr_pri && !software_reset_request_go && prot_en |=> $stable(presc_r);
  endproperty
  a_prot_hold: assert property (p_prot_hold)
    else $error("primary field changed while enabled");

  property p_auto_lock_update;
    auto_lock_update_r && running && OVF_EVT_I |=> lock_buffer_update_r;
  endproperty
  a_auto_lock_update: assert property (p_auto_lock_update)
    else $error("auto lock did not set lock bit");

  property p_reload_now;
    retrig && psync_r == PSYNC_GCLK |=> COUNT_RELOAD_O;
  endproperty
  a_reload_now: assert property (p_reload_now)
    else $error("reload not issued on next clock");

  property p_presc_range;
    running |-> pcnt_r <= pterm;
  endproperty
  a_presc_range: assert property (p_presc_range)
    else $error("prescaler count past terminal");

  property p_en_busy;
    en_go && !sbusy[0] |=> sbusy[1] [*3];
  endproperty
  a_en_busy: assert property (p_en_busy)
    else $error("enable busy flag too short");

  property p_software_reset_request_discard;
    software_reset_request_go && !sbusy[0] |=> software_reset_request_r && $stable(res_r)
      && $stable(enable_bit_r);
  endproperty
  a_software_reset_request_discard: assert property (p_software_reset_request_discard)
    else $error("reset write changed other fields");

  property p_software_reset_request_end;
    sdone[0] |=> !software_reset_request_r && !sbusy[0] && !enabled_r;
  endproperty
  a_software_reset_request_end: assert property (p_software_reset_request_end)
    else $error("reset bit or busy not cleared together");

  property p_cmd_clear;
    exec && !apply_set |=> pend_r == CMD_NONE;
  endproperty
  a_cmd_clear: assert property (p_cmd_clear)
    else $error("executed command still pending");

  property p_wp_block;
    wr_fire && WP_EN_I |-> sgo == 3'h0;
  endproperty
  a_wp_block: assert property (p_wp_block)
    else $error("protected write was taken");

  property p_lock_copy;
    UPD_COND_I && lock_buffer_update_r && cpten_r == 4'h0 |=> !BUF_COPY_O;
  endproperty
  a_lock_copy: assert property (p_lock_copy)
    else $error("buffer copied while locked");

  c_software_reset_request: cover property (software_reset_request_go ##[1:20] SOFT_RESET_O);
  c_cmd:   cover property (exec && pend_r == CMD_RETRIG);
  c_relw:  cover property (reload_wait_r && tick ##1 COUNT_RELOAD_O);
  c_rsyn:  cover property (retrig && psync_r == PSYNC_RESYNC);
endmodule : control_timer_ctrl_regs

// file: ctrl_timer_pkg.sv
package ctrl_timer_pkg;
  localparam logic [7:0] IDX_PRIMARY = 8'h00;
  localparam logic [7:0] IDX_CLEAR   = 8'h04;
  localparam logic [7:0] IDX_SET     = 8'h05;
  localparam logic [7:0] IDX_BUSY    = 8'h08;
  localparam int ADDR_W       = 6;
  localparam int SOFTWARE_RESET_REQUEST_BIT    = 0;
  localparam int ENABLE_BIT   = 1;
  localparam int RES_LSB      = 5;
  localparam int PRESC_LSB    = 8;
  localparam int RUN_IN_STANDBY_BIT = 11;
  localparam int PSYNC_LSB    = 12;
  localparam int AUTO_LOCK_UPDATE_BIT    = 14;
  localparam int CPTEN_LSB    = 24;
  localparam int LOCK_BUFFER_UPDATE_BIT     = 1;
  localparam int CMD_LSB      = 5;
  localparam int BUSY_SOFTWARE_RESET_REQUEST   = 0;
  localparam int BUSY_ENABLE  = 1;
  localparam int BUSY_CTRLB   = 2;
  localparam logic [31:0] PRIMARY_RST = 32'h0000_0000;
  localparam logic [7:0]  CTRLB_RST   = 8'h00;
  localparam int SYNC_CYCLES  = 3;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {
    CMD_NONE     = 3'h0,
    CMD_RETRIG   = 3'h1,
    CMD_STOP     = 3'h2,
    CMD_UPDATE   = 3'h3,
    CMD_COUNT_READ_SYNC_COMMAND = 3'h4
  } cmd_t;
  typedef enum logic [1:0] {
    PSYNC_GCLK   = 2'h0,
    PSYNC_PRESC  = 2'h1,
    PSYNC_RESYNC = 2'h2,
    PSYNC_RSVD   = 2'h3
  } psync_t;
endpackage : ctrl_timer_pkg

// file: control_timer_ctrl_regs_tb.sv
module control_timer_ctrl_regs_tb import ctrl_timer_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  // longer sync than default so busy flags can be read before they clear
  localparam int SYNC = 8;
  logic        clk, rst, awv, wv, bry, arv, rry, wp, stby, ovf, upd;
  logic        awrdy, wrdy, bvld, arrdy, rvld, run, tick, rld, stp, rsy;
  logic        cpy, lck, srst, ret;
  logic [5:0]  awa, ara;
  logic [31:0] wd, rdo;
  logic [3:0]  ws, cap;
  logic [2:0]  dith;
  logic [1:0]  br, rr, resp;
  int          bad_count = 0;
  int          compares = 0;
  int          cyc = 0;
  int          last_t = 0;
  int          period = 0;
  int          n_tick = 0;
  int          cnt[5] = '{0, 0, 0, 0, 0};
  int          dv[8] = '{1, 2, 4, 8, 16, 64, 256, 1024};
  logic [2:0]  cd[5] = '{3'h1, 3'h3, 3'h4, 3'h5, 3'h2};

  control_timer_ctrl_regs #(.SYNC_LEN(SYNC)) i_control_timer_ctrl_regs (
    .CLOCK_I(clk), .RST_I(rst), .CE_I(1'b1),
    .AWADDR_I(awa), .AWVALID_I(awv), .AWREADY_O(awrdy),
    .WDATA_I(wd), .WSTRB_I(ws), .WVALID_I(wv), .WREADY_O(wrdy),
    .BRESP_O(br), .BVALID_O(bvld), .BREADY_I(bry),
    .ARADDR_I(ara), .ARVALID_I(arv), .ARREADY_O(arrdy),
    .RDATA_O(rdo), .RRESP_O(rr), .RVALID_O(rvld), .RREADY_I(rry),
    .WP_EN_I(wp), .STANDBY_I(stby), .OVF_EVT_I(ovf),
    .RETRIG_EVT_I(ret), .UPD_COND_I(upd),
    .TIMER_RUN_O(run), .PRESC_TICK_O(tick), .COUNT_RELOAD_O(rld),
    .CMD_STOP_O(stp), .CMD_COUNT_READ_SYNC_COMMAND_O(rsy), .BUF_COPY_O(cpy),
    .LOCK_UPDATE_O(lck), .SOFT_RESET_O(srst), .CAPTURE_EN_O(cap),
    .DITHER_BITS_O(dith)
  );

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // pulse outputs last one cycle, so they are counted on every edge
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (tick === 1'b1)
    begin
      period <= cyc - last_t;
      last_t <= cyc;
      n_tick <= n_tick + 1;
    end
    if (srst === 1'b1) cnt[0] <= cnt[0] + 1;
    if (rld === 1'b1) cnt[1] <= cnt[1] + 1;
    if (stp === 1'b1) cnt[2] <= cnt[2] + 1;
    if (cpy === 1'b1) cnt[3] <= cnt[3] + 1;
    if (rsy === 1'b1) cnt[4] <= cnt[4] + 1;
  end

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask : idle

  task automatic wr(input logic [5:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    @(posedge clk);
    awa <= a;
    wd <= d;
    ws <= s;
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    do
    begin
      @(posedge clk);
      if (awrdy === 1'b1) awv <= 1'b0;
      if (wrdy === 1'b1) wv <= 1'b0;
    end
    while (bvld !== 1'b1);
    resp = br;
    bry <= 1'b0;
  endtask : wr

  task automatic rchk(input string nm, input logic [5:0] a,
                      input logic [31:0] e);
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    do
    begin
      @(posedge clk);
      if (arrdy === 1'b1) arv <= 1'b0;
    end
    while (rvld !== 1'b1);
    resp = rr;
    rry <= 1'b0;
    chk(nm, e, rdo);
  endtask : rchk

  task automatic wait_tick();
    int t;
    t = n_tick;
    while (n_tick == t) @(posedge clk);
  endtask : wait_tick

  task automatic pulse_evt(input bit which);
    if (which) ovf <= 1'b1;
    else upd <= 1'b1;
    @(posedge clk);
    ovf <= 1'b0;
    upd <= 1'b0;
    idle(3);
  endtask : pulse_evt

  task automatic t_reset();
    rchk("primary", 6'h00, 32'h0);
    rchk("secondary", 6'h14, 32'h0);
    rchk("busy", 6'h20, 32'h0);
    rchk("unmapped data", 6'h3c, 32'h0);
    chk("unmapped rresp", 32'(RESP_SLVERR), 32'(resp));
    wr(6'h3c, 32'h1, 4'hf);
    chk("unmapped bresp", 32'(RESP_SLVERR), 32'(resp));
    $display("test reset done");
  endtask : t_reset

  task automatic t_fields();
    wr(6'h00, 32'hffff_fffc, 4'hf);
    // the reserved psync code 3 is dropped, so bits 13:12 stay zero
    rchk("fields", 6'h00, 32'h0f00_4f60);
    chk("capture", 32'hf, 32'(cap));
    for (int r = 0; r < 4; r++)
    begin
      wr(6'h00, 32'(r << 5), 4'h1);
      idle(2);
      chk("dither", 32'((r == 0) ? 0 : r + 3), 32'(dith));
    end
    rchk("byte lane", 6'h00, 32'h0f00_4f60);
    $display("test fields done");
  endtask : t_fields

  task automatic t_enable();
    wr(6'h00, 32'h62, 4'h1);
    rchk("enable readback", 6'h00, 32'h0f00_4f62);
    rchk("enable busy", 6'h20, 32'h2);
    idle(SYNC + 2);
    rchk("enable settled", 6'h20, 32'h0);
    chk("running", 32'h1, 32'(run));
    wr(6'h00, 32'h2, 4'hf);
    rchk("protected", 6'h00, 32'h0f00_4f62);
    stby <= 1'b1;
    idle(3);
    chk("run in standby", 32'h1, 32'(run));
    stby <= 1'b0;
    $display("test enable done");
  endtask : t_enable

  task automatic t_presc();
    for (int k = 0; k < 8; k++)
    begin
      wr(6'h00, 32'h0, 4'hf);
      idle(SYNC + 2);
      wr(6'h00, {21'h0, k[2:0], 8'h02}, 4'hf);
      wait_tick();
      wait_tick();
      wait_tick();
      chk("tick period", 32'(dv[k]), 32'(period));
    end
    stby <= 1'b1;
    idle(3);
    chk("halt in standby", 32'h0, 32'(run));
    stby <= 1'b0;
    idle(3);
    $display("test prescaler done");
  endtask : t_presc

  task automatic t_cmd();
    int snap[5];
    // start just after a tick so the pending command is seen before it runs
    wait_tick();
    wr(6'h14, 32'h40, 4'h1);
    idle(SYNC + 2);
    rchk("pending", 6'h10, 32'h40);
    snap = cnt;
    wr(6'h10, 32'h40, 4'h1);
    idle(SYNC + 2);
    rchk("cancelled", 6'h14, 32'h0);
    wait_tick();
    idle(3);
    chk("no stop", 32'(snap[2]), 32'(cnt[2]));
    for (int i = 0; i < 5; i++)
    begin
      snap = cnt;
      wait_tick();
      wr(6'h14, {24'h0, cd[i], 5'h0}, 4'h1);
      wait_tick();
      idle(3);
      rchk("command cleared", 6'h14, 32'h0);
      for (int j = 1; j < 5; j++)
        chk("command out", 32'(snap[j] + (j == cd[i])), 32'(cnt[j]));
    end
    $display("test commands done");
  endtask : t_cmd

  task automatic t_retrig(input logic [31:0] ctl, input logic [31:0] e_now,
                          input int e_per);
    int s;
    wr(6'h00, 32'h0, 4'hf);
    idle(SYNC + 2);
    wr(6'h00, ctl, 4'hf);
    idle(SYNC + 2);
    s = cnt[1];
    wait_tick();
    ret <= 1'b1;
    @(posedge clk);
    ret <= 1'b0;
    @(posedge clk);
    chk("reload timing", e_now, 32'(rld));
    wait_tick();
    idle(2);
    chk("reload count", 32'(s + 1), 32'(cnt[1]));
    chk("tick after retrigger", 32'(e_per), 32'(period));
    $display("test retrigger done");
  endtask : t_retrig

  task automatic t_lock();
    int s;
    wr(6'h00, 32'h0, 4'hf);
    idle(SYNC + 2);
    // auto lock only reacts to events of a running timer
    wr(6'h00, 32'h0000_4002, 4'hf);
    idle(SYNC + 2);
    pulse_evt(1'b1);
    chk("auto lock", 32'h1, 32'(lck));
    rchk("lock readback", 6'h14, 32'h2);
    s = cnt[3];
    pulse_evt(1'b0);
    chk("locked copy", 32'(s), 32'(cnt[3]));
    wr(6'h00, 32'h0, 4'h1);
    idle(SYNC + 2);
    wr(6'h00, 32'h0100_4000, 4'hf);
    pulse_evt(1'b0);
    chk("capture copy", 32'(s + 1), 32'(cnt[3]));
    wp <= 1'b1;
    wr(6'h00, 32'h0000_0800, 4'hf);
    wp <= 1'b0;
    rchk("write protect", 6'h00, 32'h0100_4000);
    $display("test lock done");
  endtask : t_lock

  task automatic t_software_reset_request();
    int s;
    s = cnt[0];
    wr(6'h00, 32'h0f00_0803, 4'hf);
    rchk("reset readback", 6'h00, 32'h0100_4001);
    rchk("reset busy", 6'h20, 32'h1);
    idle(SYNC + 2);
    rchk("after reset", 6'h00, 32'h0);
    rchk("busy after reset", 6'h20, 32'h0);
    rchk("lock after reset", 6'h14, 32'h0);
    chk("reset pulse", 32'(s + 1), 32'(cnt[0]));
    chk("capture off", 32'h0, 32'(cap));
    $display("test soft reset done");
  endtask : t_software_reset_request

  task automatic summarize();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : summarize

  initial
  begin
    {rst, awv, wv, bry, arv, rry, wp, stby, ovf, upd} = 10'h200;
    {awa, ara, wd, ws} = '0;
    ret = 1'b0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_fields();
    t_enable();
    t_presc();
    t_cmd();
    t_retrig(32'h0000_1202, 32'h0, 4);
    t_retrig(32'h0000_2202, 32'h1, 7);
    t_lock();
    t_software_reset_request();
    summarize();
  end

  // the slowest test, t_cmd, runs about twelve thousand cycles
  initial
  begin
    repeat (60000) @(posedge clk);
    bad_count++;
    $display("BAD watchdog expected finish seen hang");
    summarize();
  end
endmodule : control_timer_ctrl_regs_tb
